// file: rtl/io_status_defines.svh
`ifndef IO_STATUS_DEFINES_SVH
`define IO_STATUS_DEFINES_SVH
// ----------------------------------------
// register offsets (address bits 28-31)
// ----------------------------------------
`define OFS_GEN_STATUS   4'hB
`define OFS_DMA_REMAP    4'hC
`define OFS_MOD_CONFIG   4'hD
`define OFS_FP_STATUS    4'hE
`define OFS_COP_OPCODE   4'hF
// ----------------------------------------
// bit positions, ibm-style bit 0 = msb, mapped to lsb index 31-n
// ----------------------------------------
`define GS_WRITE         30
`define GS_XLATE         26
`define GS_NOREPORT_IO   16
`define GS_NOBUSY        15
`define GS_EXC_SP        14
`define GS_BAD_WDATA     13
`define GS_TGT_PAR       12
`define GS_REPLY_IND     11
`define GS_REPLY_ERR     10
`define GS_SP_ACCEPT     9
`define GS_NOREPORT_MU   1
`define GS_IRQ5          0
`define MU_ERR_LSB       2
`define FP_ADDR_LSB      10
`define FP_AHEAD         8
`define FP_COP_EXC       1
`define FP_COP_INC       0
`define MU_ERR_MASK      6'h3B
`define CFG_STRAP_LSB    8
`define CFG_TAG_LSB      5
`define CFG_ARB_LSB      0
`define CFG_WR_MASK      32'h00000067
`endif

// file: rtl/io_status_pkg.sv
package io_status_pkg;
  typedef logic [31:0] word_t;
  typedef logic [5:0]  mu_err_t;
  typedef logic [6:0]  fp_addr_t;
endpackage

// file: rtl/io_module_status_config_regs.sv
`timescale 1ns/1ps
`include "io_status_defines.svh"
module io_module_status_config_regs
  import io_status_pkg::*;
#(
  parameter int STRAP_W = 8
) (
  input  wire logic               clk_sys,
  input  wire logic               reset,
  input  wire logic               acc_valid,
  input  wire logic               acc_write,
  input  wire logic [31:0]        acc_addr,
  input  wire logic [31:0]        acc_wdata,
  input  wire logic [7:0]         io_base,
  output logic                    acc_ack,
  output logic [31:0]             acc_rdata,
  input  wire logic               ev_dma_hit,
  input  wire logic               ev_req_write,
  input  wire logic               ev_req_xlate,
  input  wire logic               ev_noreport_io,
  input  wire logic               ev_nobusy,
  input  wire logic               ev_exc_sp,
  input  wire logic               ev_bad_wdata,
  input  wire logic               ev_tgt_parity,
  input  wire logic               ev_reply_ind,
  input  wire logic               ev_reply_err,
  input  wire logic               ev_sp_accept,
  input  wire logic [5:0]         ev_mu_err,
  input  wire logic               ev_noreport_mu,
  input  wire logic               irq5_line,
  input  wire logic               sp_req,
  input  wire logic               serialize_disable,
  output logic                    sp_force_exc,
  output logic                    irq2_out,
  input  wire logic [STRAP_W-1:0] feature_strap_input,
  output logic [1:0]              dma_tag,
  output logic [2:0]              arb_level,
  input  wire logic [3:0]         dma_in_subseg,
  input  wire logic [1:0]         dma_in_piece,
  input  wire logic [15:0]        subseg_present,
  output logic                    remap_hit,
  output logic [1:0]              remap_piece,
  input  wire logic               fp_err,
  input  wire logic [6:0]         fp_err_addr,
  input  wire logic               fp_err_ahead,
  input  wire logic [5:0]         fp_mu_err,
  input  wire logic               fp_cop_exc,
  input  wire logic               fp_cop_incomplete,
  input  wire logic               cop_pc_req,
  input  wire logic [15:0]        cop_opcode
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  word_t    gsr_ff, nxt_gsr;
  word_t    fsr_ff, nxt_fsr;
  logic [15:0] remap_ff, nxt_remap;
  logic [4:0]  cfg_ff, nxt_cfg;
  logic [15:0] opc_ff, nxt_opc;
  logic     ser_ff, nxt_ser;
  logic     ack_ff, nxt_ack;
  word_t    rdata_ff, nxt_rdata;
  logic     irq2_ff, nxt_irq2;
  logic     rhit_ff, nxt_rhit;
  logic [1:0] rpiece_ff, nxt_rpiece;
  logic     hit, rd, wr;
  logic [3:0] ofs;
  logic     fp_held;

  // bit n of the ibm numbering of a 16-bit field is index 15-n
  function automatic logic sel(input logic [15:0] v, input logic [3:0] i);
    return v[4'hF - i];
  endfunction

  assign hit = acc_valid && (acc_addr[23:16] == io_base) && (acc_addr[15:4] == 12'h000);
  assign ofs = acc_addr[3:0];
  assign rd  = hit && !acc_write;
  assign wr  = hit && acc_write;
  // any recorded fp status freezes the address, even a zero one
  assign fp_held = |fsr_ff;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_gsr = gsr_ff;
    nxt_fsr = fsr_ff;
    nxt_remap = remap_ff;
    nxt_cfg = cfg_ff;
    nxt_opc = opc_ff;
    nxt_ser = ser_ff;
    nxt_rdata = 32'h00000000;
    nxt_ack = hit;
    // read clears first, new events set afterwards so a set wins
    if (rd && ofs == `OFS_GEN_STATUS) begin
      nxt_gsr = 32'h00000000;
      nxt_ser = 1'b0;
    end
    if (rd && ofs == `OFS_FP_STATUS) begin
      nxt_fsr = 32'h00000000;
    end
    if (ev_dma_hit) begin
      if (ev_req_write) nxt_gsr[`GS_WRITE] = 1'b1;
      if (ev_req_xlate) nxt_gsr[`GS_XLATE] = 1'b1;
      nxt_gsr[`MU_ERR_LSB +: 6] = nxt_gsr[`MU_ERR_LSB +: 6] | (ev_mu_err & `MU_ERR_MASK);
    end
    if (ev_noreport_io) nxt_gsr[`GS_NOREPORT_IO] = 1'b1;
    if (ev_nobusy) nxt_gsr[`GS_NOBUSY] = 1'b1;
    if (ev_exc_sp) nxt_gsr[`GS_EXC_SP] = 1'b1;
    if (ev_bad_wdata) nxt_gsr[`GS_BAD_WDATA] = 1'b1;
    if (ev_tgt_parity) nxt_gsr[`GS_TGT_PAR] = 1'b1;
    if (ev_reply_ind) nxt_gsr[`GS_REPLY_IND] = 1'b1;
    if (ev_reply_err) nxt_gsr[`GS_REPLY_ERR] = 1'b1;
    if (ev_sp_accept) nxt_gsr[`GS_SP_ACCEPT] = 1'b1;
    if (ev_noreport_mu) nxt_gsr[`GS_NOREPORT_MU] = 1'b1;
    nxt_gsr[`GS_IRQ5] = 1'b0; // live bit is merged on read
    if (ev_exc_sp && !serialize_disable) nxt_ser = 1'b1;
    // first error address frozen until read
    if (fp_err && !fp_held) begin
      nxt_fsr[`FP_ADDR_LSB +: 7] = fp_err_addr;
      nxt_fsr[`FP_AHEAD] = fp_err_ahead;
    end
    if (fp_err) begin
      nxt_fsr[`MU_ERR_LSB +: 6] = nxt_fsr[`MU_ERR_LSB +: 6] | (fp_mu_err & `MU_ERR_MASK);
    end
    if (fp_cop_exc) nxt_fsr[`FP_COP_EXC] = 1'b1;
    if (fp_cop_incomplete) nxt_fsr[`FP_COP_INC] = 1'b1;
    if (wr) begin
      unique case (ofs)
        `OFS_DMA_REMAP:  nxt_remap = acc_wdata[31:16];
        `OFS_MOD_CONFIG: nxt_cfg = {acc_wdata[`CFG_TAG_LSB +: 2], acc_wdata[`CFG_ARB_LSB +: 3]};
        `OFS_COP_OPCODE: nxt_opc = acc_wdata[15:0];
        default: ;
      endcase
    end
    if (cop_pc_req) nxt_opc = cop_opcode;
    if (rd) begin
      unique case (ofs)
        `OFS_GEN_STATUS: nxt_rdata = gsr_ff | {31'h00000000, irq5_line};
        `OFS_DMA_REMAP:  nxt_rdata = {remap_ff, 16'h0000};
        `OFS_MOD_CONFIG: nxt_rdata = {16'h0000, feature_strap_input, 1'b0, cfg_ff[4:3], 2'b00, cfg_ff[2:0]};
        `OFS_FP_STATUS:  nxt_rdata = fsr_ff;
        `OFS_COP_OPCODE: nxt_rdata = {16'h0000, opc_ff};
        default:         nxt_rdata = 32'h00000000;
      endcase
    end
    nxt_irq2 = nxt_gsr[`GS_NOREPORT_IO] | nxt_gsr[`GS_NOREPORT_MU];
    // remap fields: bits 0-3 new bit8, 4-7 new bit9, 8-11 present, 12-15 subsegment
    nxt_rhit = (dma_in_subseg == remap_ff[3:0]) && !sel(subseg_present, dma_in_subseg)
               && remap_ff[4'h7 - {2'b00, dma_in_piece}];
    nxt_rpiece = {remap_ff[4'hF - {2'b00, dma_in_piece}], remap_ff[4'hB - {2'b00, dma_in_piece}]};
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gsr_ff <= 32'h00000000;
      fsr_ff <= 32'h00000000;
      remap_ff <= 16'h0000;
      cfg_ff <= 5'h00;
      opc_ff <= 16'h0000;
      ser_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      irq2_ff <= 1'b0;
      rhit_ff <= 1'b0;
      rpiece_ff <= 2'b00;
    end else begin
      gsr_ff <= nxt_gsr;
      fsr_ff <= nxt_fsr;
      remap_ff <= nxt_remap;
      cfg_ff <= nxt_cfg;
      opc_ff <= nxt_opc;
      ser_ff <= nxt_ser;
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
      irq2_ff <= nxt_irq2;
      rhit_ff <= nxt_rhit;
      rpiece_ff <= nxt_rpiece;
    end
  end

  assign acc_ack = ack_ff;
  assign acc_rdata = rdata_ff;
  assign sp_force_exc = ser_ff;
  assign irq2_out = irq2_ff;
  assign dma_tag = cfg_ff[4:3];
  assign arb_level = cfg_ff[2:0];
  assign remap_hit = rhit_ff;
  assign remap_piece = rpiece_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_exc;
    ev_exc_sp && !serialize_disable;
  endsequence
  sequence s_gsr_read;
    rd && ofs == `OFS_GEN_STATUS;
  endsequence

  a_serial_entry: assert property (@(posedge clk_sys) disable iff (reset) s_exc |=> sp_force_exc)
    else $error("serializing state not entered");
  a_serial_exit: assert property (@(posedge clk_sys) disable iff (reset)
    s_gsr_read and !ev_exc_sp |=> !sp_force_exc)
    else $error("serializing state not left on read");
  a_nobusy_set: assert property (@(posedge clk_sys) disable iff (reset) ev_nobusy |=> gsr_ff[`GS_NOBUSY])
    else $error("no busy bit not set");
  a_sticky_bits: assert property (@(posedge clk_sys) disable iff (reset)
    gsr_ff[`GS_TGT_PAR] && !(rd && ofs == `OFS_GEN_STATUS) |=> gsr_ff[`GS_TGT_PAR])
    else $error("status bit lost without read");
  a_dma_filter: assert property (@(posedge clk_sys) disable iff (reset)
    !ev_dma_hit && !gsr_ff[`GS_WRITE] |=> !gsr_ff[`GS_WRITE])
    else $error("write bit set off dma path");
  a_irq2_follow: assert property (@(posedge clk_sys) disable iff (reset)
    irq2_out == (gsr_ff[`GS_NOREPORT_IO] | gsr_ff[`GS_NOREPORT_MU]))
    else $error("level 2 interrupt mismatch");
  a_fp_hold: assert property (@(posedge clk_sys) disable iff (reset)
    fp_held && !(rd && ofs == `OFS_FP_STATUS) |=> $stable(fsr_ff[`FP_ADDR_LSB +: 7]))
    else $error("fp address changed before read");
  a_opcode_load: assert property (@(posedge clk_sys) disable iff (reset)
    cop_pc_req |=> opc_ff == $past(cop_opcode))
    else $error("opcode not loaded");
  a_arb_write: assert property (@(posedge clk_sys) disable iff (reset)
    wr && ofs == `OFS_MOD_CONFIG |=> arb_level == $past(acc_wdata[2:0]))
    else $error("arbitration level not written");
  a_irq5_read: assert property (@(posedge clk_sys) disable iff (reset)
    s_gsr_read |=> acc_ack && acc_rdata[`GS_IRQ5] == $past(irq5_line))
    else $error("level 5 bit not live");

  sequence s_fp_read;
    rd && ofs == `OFS_FP_STATUS;
  endsequence

  a_xlate_capture: assert property (@(posedge clk_sys) disable iff (reset)
    ev_dma_hit && ev_req_xlate |=> gsr_ff[`GS_XLATE])
    else $error("translate bit not captured");
  a_mu_filter: assert property (@(posedge clk_sys) disable iff (reset)
    !ev_dma_hit && gsr_ff[`MU_ERR_LSB +: 6] == 6'h00 |=> gsr_ff[`MU_ERR_LSB +: 6] == 6'h00)
    else $error("memory channel bits set off dma path");
  a_noreport_io: assert property (@(posedge clk_sys) disable iff (reset)
    ev_noreport_io |=> gsr_ff[`GS_NOREPORT_IO])
    else $error("unreportable write bit not set");
  a_exc_set: assert property (@(posedge clk_sys) disable iff (reset)
    ev_exc_sp |=> gsr_ff[`GS_EXC_SP])
    else $error("exception bit not set");
  a_wdata_parity: assert property (@(posedge clk_sys) disable iff (reset)
    ev_bad_wdata |=> gsr_ff[`GS_BAD_WDATA])
    else $error("write data parity bit not set");
  a_reply_err: assert property (@(posedge clk_sys) disable iff (reset)
    ev_reply_err |=> gsr_ff[`GS_REPLY_ERR])
    else $error("reply error bit not set");
  a_mu_capture: assert property (@(posedge clk_sys) disable iff (reset)
    ev_dma_hit && ev_mu_err[5] |=> gsr_ff[`MU_ERR_LSB + 5])
    else $error("no response bit not set");
  a_noreport_mu: assert property (@(posedge clk_sys) disable iff (reset)
    ev_noreport_mu |=> gsr_ff[`GS_NOREPORT_MU])
    else $error("unreportable dma bit not set");
  a_remap_present: assert property (@(posedge clk_sys) disable iff (reset)
    sel(subseg_present, dma_in_subseg) |=> !remap_hit)
    else $error("remap hit on present subsegment");
  a_remap_select: assert property (@(posedge clk_sys) disable iff (reset)
    dma_in_subseg != remap_ff[3:0] |=> !remap_hit)
    else $error("remap hit on other subsegment");
  a_strap_read: assert property (@(posedge clk_sys) disable iff (reset)
    rd && ofs == `OFS_MOD_CONFIG |=> acc_rdata[`CFG_STRAP_LSB +: STRAP_W] == $past(feature_strap_input))
    else $error("strap levels not shown");
  a_fp_ahead: assert property (@(posedge clk_sys) disable iff (reset)
    fp_err && !fp_held |=> fsr_ff[`FP_AHEAD] == $past(fp_err_ahead))
    else $error("ahead flag not captured");
  a_fp_cop: assert property (@(posedge clk_sys) disable iff (reset)
    fp_cop_incomplete |=> fsr_ff[`FP_COP_INC])
    else $error("incomplete bit not set");
  a_fp_clear: assert property (@(posedge clk_sys) disable iff (reset)
    s_fp_read and !(fp_err || fp_cop_exc || fp_cop_incomplete) |=> fsr_ff == 32'h00000000)
    else $error("fp status not cleared on read");
  a_miss_no_ack: assert property (@(posedge clk_sys) disable iff (reset)
    !hit |=> !acc_ack)
    else $error("ack without address hit");
  a_cfg_reserved: assert property (@(posedge clk_sys) disable iff (reset)
    rd && ofs == `OFS_MOD_CONFIG |=> (acc_rdata & ~(`CFG_WR_MASK | 32'h0000FF00)) == 32'h00000000)
    else $error("reserved config bits not zero");
  a_mu_reserved: assert property (@(posedge clk_sys) disable iff (reset)
    !gsr_ff[`MU_ERR_LSB + 2] && !fsr_ff[`MU_ERR_LSB + 2])
    else $error("reserved error bit set");
endmodule // io_module_status_config_regs

// file: verification/channel_event_source.sv
`timescale 1ns/1ps
module channel_event_source (
  input  wire logic clk_sys,
  output logic [31:0] ev,
  output logic ev_dma_hit,
  output logic [31:0] fp,
  output logic fp_err,
  output logic cop_pc_req,
  output logic [15:0] cop_opcode
);
  initial {ev, ev_dma_hit, fp, fp_err, cop_pc_req, cop_opcode} = '0;
  // ----------------------------------------
  // one-cycle fault strobes
  // ----------------------------------------
  task automatic pulse(input logic [31:0] e, input logic h, input logic [31:0] f, input logic fe,
                       input logic pc, input logic [15:0] op);
    @(posedge clk_sys);
    #1;
    {ev, ev_dma_hit, fp, fp_err} = {e, h, f, fe};
    {cop_pc_req, cop_opcode} = {pc, op};
    @(posedge clk_sys);
    #1;
    {ev, ev_dma_hit, fp, fp_err, cop_pc_req} = '0;
    cop_opcode = ~op; // opcode bus is driven to the inverse of op once the request drops
  endtask
endmodule // channel_event_source

// file: verification/io_module_status_config_regs_tb.sv
`timescale 1ns/1ps
module io_module_status_config_regs_tb;
  import io_status_pkg::*;
  logic clk_sys, reset, acc_valid, acc_write, acc_ack, sp_force_exc, irq2_out, irq5_line;
  logic serialize_disable, remap_hit, ev_dma_hit, fp_err, cop_pc_req;
  word_t acc_addr, acc_wdata, acc_rdata, ev, fp, rd;
  logic [7:0] io_base, feature_strap_input;
  logic [1:0] dma_tag, dma_in_piece, remap_piece;
  logic [2:0] arb_level;
  logic [3:0] dma_in_subseg;
  logic [15:0] subseg_present, cop_opcode;
  int miscompares, comparisons;
  localparam word_t remap_val = 32'hACB3_0000;
  typedef struct packed {word_t gen; logic hit; word_t exp;} row_t;
  row_t rows[9] = '{
    '{32'h4400_0000, 1'b1, 32'h4400_0000},
    '{32'h4400_0000, 1'b0, 32'h0000_0000},
    '{32'h0000_00FC, 1'b1, 32'h0000_00EC},
    '{32'h0000_00FC, 1'b0, 32'h0000_0000},
    '{32'h0001_0000, 1'b0, 32'h0001_0000},
    '{32'h0000_C000, 1'b0, 32'h0000_C000},
    '{32'h0000_3000, 1'b0, 32'h0000_3000},
    '{32'h0000_0E00, 1'b0, 32'h0000_0E00},
    '{32'h0000_0002, 1'b0, 32'h0000_0002}};
  io_module_status_config_regs #(.STRAP_W(8)) dut (
    .clk_sys, .reset, .acc_valid, .acc_write, .acc_addr, .acc_wdata, .io_base, .acc_ack, .acc_rdata,
    .ev_dma_hit, .ev_req_write(ev[30]), .ev_req_xlate(ev[26]), .ev_noreport_io(ev[16]),
    .ev_nobusy(ev[15]), .ev_exc_sp(ev[14]), .ev_bad_wdata(ev[13]), .ev_tgt_parity(ev[12]),
    .ev_reply_ind(ev[11]), .ev_reply_err(ev[10]), .ev_sp_accept(ev[9]), .ev_mu_err(ev[7:2]),
    .ev_noreport_mu(ev[1]), .irq5_line, .sp_req(1'b0), .serialize_disable, .sp_force_exc, .irq2_out,
    .feature_strap_input, .dma_tag, .arb_level, .dma_in_subseg, .dma_in_piece, .subseg_present,
    .remap_hit, .remap_piece, .fp_err, .fp_err_addr(fp[16:10]), .fp_err_ahead(fp[8]),
    .fp_mu_err(fp[7:2]), .fp_cop_exc(fp[1]), .fp_cop_incomplete(fp[0]), .cop_pc_req, .cop_opcode);
  channel_event_source far_end (.clk_sys, .ev, .ev_dma_hit, .fp, .fp_err, .cop_pc_req, .cop_opcode);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] ofs, input word_t wd, input logic [7:0] base = 8'h9A,
                     input logic [11:0] mid = 12'h000);
    tick();
    {acc_valid, acc_write, acc_wdata, acc_addr} = {1'b1, w, wd, 8'h00, base, mid, ofs};
    tick();
    acc_valid = 1'b0;
    rd = acc_rdata;
    chk("ack", {31'h0, acc_ack}, {31'h0, base == io_base && mid == 12'h000});
  endtask
  task automatic rdchk(input string what, input logic [3:0] ofs, input word_t exp);
    acc(1'b0, ofs, 32'h0);
    chk(what, rd, exp);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    miscompares++;
    tally_and_finish();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset, acc_valid, acc_write, irq5_line, serialize_disable} = 5'b10000;
    {acc_addr, acc_wdata, rd, subseg_present} = '0;
    {io_base, feature_strap_input, dma_in_subseg, dma_in_piece} = {8'h9A, 8'hA5, 4'h0, 2'b0};
    repeat (20) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    chk("outs", word_t'({dma_tag, arb_level, sp_force_exc, irq2_out}), 32'h0);
    rdchk("status", 4'hB, 32'h0);
    rdchk("config", 4'hD, 32'h0000_A500);
    foreach (rows[i]) begin
      far_end.pulse(rows[i].gen, rows[i].hit, 32'h0, 1'b0, 1'b0, 16'h0);
      rdchk("status", 4'hB, rows[i].exp);
      rdchk("status_clr", 4'hB, 32'h0);
    end
    acc(1'b1, 4'hD, 32'hFFFF_FFFF);
    rdchk("config", 4'hD, 32'h0000_A567);
    chk("tag_arb", word_t'({dma_tag, arb_level}), 32'h1F);
    acc(1'b1, 4'hD, 32'h0000_0044);
    acc(1'b1, 4'hD, 32'h0, 8'h9B);
    acc(1'b1, 4'hD, 32'h0, 8'h9A, 12'h010);
    chk("tag_arb", word_t'({dma_tag, arb_level}), 32'h14);
    feature_strap_input = 8'h3C;
    rdchk("straps", 4'hD, 32'h0000_3C44);
    acc(1'b1, 4'hB, 32'hFFFF_FFFF);
    irq5_line = 1'b1;
    rdchk("irq5", 4'hB, 32'h0000_0001);
    irq5_line = 1'b0;
    rdchk("irq5", 4'hB, 32'h0);
    far_end.pulse(32'h0000_4000, 1'b0, 32'h0, 1'b0, 1'b0, 16'h0);
    acc(1'b0, 4'hD, 32'h0);
    chk("serial", word_t'(sp_force_exc), 32'h1);
    rdchk("status", 4'hB, 32'h0000_4000);
    chk("serial", word_t'(sp_force_exc), 32'h0);
    far_end.pulse(32'h0000_0002, 1'b0, 32'h0, 1'b0, 1'b0, 16'h0);
    acc(1'b0, 4'hD, 32'h0);
    chk("irq2", word_t'(irq2_out), 32'h1);
    rdchk("status", 4'hB, 32'h2);
    acc(1'b0, 4'hD, 32'h0);
    chk("irq2", word_t'(irq2_out), 32'h0);
    // serializing can be switched off
    serialize_disable = 1'b1;
    far_end.pulse(32'h0000_4000, 1'b0, 32'h0, 1'b0, 1'b0, 16'h0);
    acc(1'b0, 4'hD, 32'h0);
    chk("serial_off", word_t'(sp_force_exc), 32'h0);
    rdchk("status", 4'hB, 32'h0000_4000);
    serialize_disable = 1'b0;
    // event in the same cycle as the clearing read survives it
    fork
      rdchk("set_wins", 4'hB, 32'h0);
      far_end.pulse(32'h0000_2000, 1'b0, 32'h0, 1'b0, 1'b0, 16'h0);
    join
    rdchk("set_wins", 4'hB, 32'h0000_2000);
    acc(1'b1, 4'hC, remap_val | 32'hFFFF);
    rdchk("remap", 4'hC, remap_val);
    dma_in_subseg = 4'h3;
    for (int p = 0; p < 4; p++) begin
      dma_in_piece = p[1:0];
      tick();
      chk("remap", word_t'({remap_hit, remap_piece & {2{remap_hit}}}),
          word_t'({remap_val[23-p], {remap_val[31-p], remap_val[27-p]} & {2{remap_val[23-p]}}}));
    end
    subseg_present = 16'h1000;
    tick();
    chk("present", word_t'(remap_hit), 32'h0);
    {subseg_present, dma_in_subseg} = {16'h0, 4'h4};
    tick();
    chk("subseg", word_t'(remap_hit), 32'h0);
    far_end.pulse(32'h0, 1'b0, 32'h0001_55FF, 1'b1, 1'b0, 16'h0);
    far_end.pulse(32'h0, 1'b0, 32'h0000_A800, 1'b1, 1'b0, 16'h0);
    rdchk("fp", 4'hE, 32'h0001_55EF);
    rdchk("fp_clr", 4'hE, 32'h0);
    // a zero address is frozen as well once an error is recorded
    far_end.pulse(32'h0, 1'b0, 32'h0000_0004, 1'b1, 1'b0, 16'h0);
    far_end.pulse(32'h0, 1'b0, 32'h0001_FD00, 1'b1, 1'b0, 16'h0);
    rdchk("fp_hold", 4'hE, 32'h0000_0004);
    far_end.pulse(32'h0, 1'b0, 32'h0, 1'b0, 1'b1, 16'h1234);
    rdchk("opcode", 4'hF, 32'h0000_1234);
    acc(1'b1, 4'hF, 32'hFFFF_BEEF);
    rdchk("opcode", 4'hF, 32'h0000_BEEF);
    fork
      acc(1'b1, 4'hF, 32'h0000_0BAD);
      far_end.pulse(32'h0, 1'b0, 32'h0, 1'b0, 1'b1, 16'h5678);
    join
    rdchk("opcode", 4'hF, 32'h0000_5678);
    tally_and_finish();
  end
endmodule // io_module_status_config_regs_tb
